// file: cbr_cycle_timer.sv
// Purpose: constants of the base load rotation block and the cycle timer
// Assumes: one 10 MHz clock, asynchronous active-low reset
// Notes:   the timer counts whole minutes from an enable pulse
package cbr_pkg;
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned RAMP_TICKS_PER_S = 10;
  localparam int unsigned CHG_DELAY_S      = 3;
  localparam int unsigned SEC_PER_MIN      = 60;
  localparam int unsigned RAMP_MV_PER_S    = 2000;
  localparam logic [13:0] RAMP_STEP_MV     =
    14'(RAMP_MV_PER_S / RAMP_TICKS_PER_S);
  localparam logic [9:0]  CYCLE_MIN_RST    = 10'h02D;
  localparam logic [9:0]  CYCLE_NONE       = 10'h000;
  localparam logic [13:0] SPD_MIN_RST      = 14'h07D0;
  localparam logic [1:0]  DRV_EN_RST       = 2'h3;
  localparam logic [1:0]  MIN_EN_RST       = 2'h1;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_CYCLE        = 8'h04;
  localparam logic [7:0]  REG_SPDMIN       = 8'h08;
  localparam logic [7:0]  REG_STATUS       = 8'h0C;
  localparam logic [7:0]  REG_SHED         = 8'h10;
  localparam logic [7:0]  REG_RUNTIME0     = 8'h14;
  localparam logic [7:0]  REG_RUNTIME1     = 8'h18;
  localparam logic [7:0]  REG_RUNTIME2     = 8'h1C;
  localparam int unsigned CTRL_CIRC_LT     = 0;
  localparam int unsigned CTRL_DRV_EN      = 1;
  localparam int unsigned CTRL_SPD_MODE    = 3;
  localparam int unsigned CTRL_MIN_EN      = 4;
  localparam int unsigned CYCLE_LT_POS     = 16;
  typedef enum logic [8:0] {
    CH_IDLE      = 9'h001,
    CH_MIN       = 9'h002,
    CH_MAINS_OFF = 9'h004,
    CH_ZERO      = 9'h008,
    CH_WAIT1     = 9'h010,
    CH_WAIT2     = 9'h020,
    CH_MAINS_ON  = 9'h040,
    CH_DRV_ON    = 9'h080,
    CH_RAMP      = 9'h100
  } cbr_chg_state_type;
endpackage : cbr_pkg

`timescale 1ns/1ps
module cbr_cycle_timer
  import cbr_pkg::*;
#(
  parameter int unsigned W = 10
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         min_tick,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } cbr_tmr_type;

  cbr_tmr_type s_q;
  cbr_tmr_type s_d;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.cnt = '0;
      s_d.exp = 1'b0;
    end else if (min_tick && limit != CYCLE_NONE && !s_q.exp) begin
      // a limit of none never expires
      s_d.cnt = s_q.cnt + 1'b1;
      if (s_d.cnt >= limit) begin
        s_d.exp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.exp;
endmodule : cbr_cycle_timer

// file: cbr_rotation.sv
// Purpose: base load rotation, drive changeover and load shedding
// Assumes: compressors 0 and 1 can sit on the speed drive, 2 is fixed
// Notes:   registers over classic Wishbone, ack one cycle after strobe
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module cbr_rotation
  import cbr_pkg::*;
#(
  parameter int unsigned NCOMP      = 3,
  parameter int unsigned SEC_CYCLES = CLK_HZ
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             stage_up_i,
  input  wire logic             stage_down_i,
  input  wire logic             cap_up_i,
  input  wire logic             cap_down_i,
  input  wire logic             press_rising_i,
  input  wire logic             neutral_zone_i,
  input  wire logic             shed_msg_i,
  input  wire logic [13:0]      speed_req_mv_i,
  input  wire logic [NCOMP-1:0] comp_fault_i,
  input  wire logic [1:0]       drive_relay_nv_i,
  output logic      [NCOMP-1:0] comp_on_o,
  output logic      [NCOMP-1:0] cap_on_o,
  output logic                  relay7_o,
  output logic                  relay8_o,
  output logic      [13:0]      speed_cmd_mv_o,
  output logic                  postinj_avail_o,
  output logic                  desuper_avail_o
);
  localparam int unsigned RAMP_CYCLES = SEC_CYCLES / RAMP_TICKS_PER_S;
  localparam logic [23:0] SEC_LAST    = 24'(SEC_CYCLES - 1);
  localparam logic [23:0] RAMP_LAST   = 24'(RAMP_CYCLES - 1);
  localparam logic [5:0]  MIN_LAST    = 6'(SEC_PER_MIN - 1);
  localparam logic [1:0]  WAIT_LAST   = 2'(CHG_DELAY_S - 1);

  typedef struct packed {
    logic                        ack;
    logic [31:0]                 dat;
    logic                        circ_lt;
    logic [1:0]                  drv_en;
    logic                        spd_mode;
    logic [1:0]                  min_en;
    logic [9:0]                  cyc_mt;
    logic [9:0]                  cyc_lt;
    logic [13:0]                 spd_min;
    logic [NCOMP-1:0]            on;
    logic [NCOMP-1:0]            cap;
    logic [NCOMP-1:0]            shed;
    logic [1:0]                  dsel;
    cbr_chg_state_type           st;
    logic                        both;
    logic [13:0]                 hold;
    logic [13:0]                 spd;
    logic [1:0]                  wait_s;
    logic [23:0]                 sec_cnt;
    logic [23:0]                 ramp_cnt;
    logic [5:0]                  min_cnt;
    logic                        min_tick;
    logic                        pend;
    logic                        all_off_prev;
    logic [1:0]                  init;
    logic [NCOMP-1:0]            f_s1;
    logic [NCOMP-1:0]            f_s2;
    logic [NCOMP-1:0]            f_prev;
    logic [1:0]                  nv_s1;
    logic [1:0]                  nv_s2;
    logic                        postinj;
    logic [NCOMP-1:0][31:0]      rt;
  } cbr_state_type;

  cbr_state_type s_q;
  cbr_state_type s_d;
  logic          restart;
  logic          exp_mt;
  logic          exp_lt;

  function automatic logic [1:0] pick_idx(
    input logic [NCOMP-1:0]       m,
    input logic [NCOMP-1:0][31:0] rt,
    input logic                   hi
  );
    logic [1:0]  k;
    logic [31:0] best;
    logic        found;
    k = '0;
    best = '0;
    found = 1'b0;
    for (int i = 0; i < NCOMP; i++) begin
      if (m[i] && (!found || (hi ? rt[i] > best : rt[i] < best))) begin
        k = 2'(i);
        best = rt[i];
        found = 1'b1;
      end
    end
    return k;
  endfunction : pick_idx

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    logic              sec_tick;
    logic              ramp_tick;
    logic [NCOMP-1:0]  fault;
    logic [NCOMP-1:0]  frise;
    logic              a;
    logic              drv;
    logic [1:0]        di;
    logic [1:0]        mi;
    logic [9:0]        cyc;
    logic              expd;
    logic              cond;
    logic [NCOMP-1:0]  excl;
    logic [NCOMP-1:0]  out_m;
    logic [NCOMP-1:0]  in_m;
    logic [1:0]        oi;
    logic [1:0]        ii;
    logic [2:0]        n_en;
    logic [2:0]        floor_en;
    logic [31:0]       w;
    logic              wr;
    logic              start;
    logic [14:0]       nxt_spd;
    sec_tick = 1'b0;
    ramp_tick = 1'b0;
    s_d = s_q;
    restart = 1'b0;
    fault = s_q.f_s2;
    frise = fault & ~s_q.f_prev;
    a = s_q.circ_lt;
    drv = s_q.dsel[a];
    di = {1'b0, drv};
    mi = {1'b0, ~drv};
    cyc = a ? s_q.cyc_lt : s_q.cyc_mt;
    expd = (a ? exp_lt : exp_mt) && cyc != CYCLE_NONE;
    s_d.f_s1 = comp_fault_i;
    s_d.f_s2 = s_q.f_s1;
    s_d.f_prev = fault;
    s_d.nv_s1 = drive_relay_nv_i;
    s_d.nv_s2 = s_q.nv_s1;
    s_d.min_tick = 1'b0;
    // slow timebase: second, tenth of a second and minute enables
    if (s_q.sec_cnt == SEC_LAST) begin
      s_d.sec_cnt = '0;
      sec_tick = 1'b1;
      s_d.min_cnt = (s_q.min_cnt == MIN_LAST) ? '0 : s_q.min_cnt + 1'b1;
      s_d.min_tick = (s_q.min_cnt == MIN_LAST);
    end else begin
      s_d.sec_cnt = s_q.sec_cnt + 1'b1;
    end
    if (s_q.ramp_cnt == RAMP_LAST) begin
      s_d.ramp_cnt = '0;
      ramp_tick = 1'b1;
    end else begin
      s_d.ramp_cnt = s_q.ramp_cnt + 1'b1;
    end
    // relay state restored from retained store once inputs settle
    if (s_q.init != 2'h3) begin
      s_d.init = s_q.init + 1'b1;
      if (s_q.init == 2'h2) begin
        s_d.dsel = s_q.nv_s2;
      end
    end
    for (int i = 0; i < NCOMP; i++) begin
      if (sec_tick) begin
        s_d.rt[i] = s_q.rt[i] + {31'h0, s_q.on[i]};
      end
    end
    // register bus
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    wr = s_d.ack && wb_we_i;
    s_d.dat = '0;
    w = '0;
    unique case (wb_adr_i)
      REG_CTRL: begin
        w = {26'h0, s_q.min_en, s_q.spd_mode, s_q.drv_en, s_q.circ_lt};
        if (wr) begin
          w = merge(w, wb_dat_i, wb_sel_i);
          s_d.circ_lt = w[CTRL_CIRC_LT];
          s_d.drv_en = w[CTRL_DRV_EN +: 2];
          s_d.spd_mode = w[CTRL_SPD_MODE];
          s_d.min_en = w[CTRL_MIN_EN +: 2];
        end
      end
      REG_CYCLE: begin
        w = {6'h0, s_q.cyc_lt, 6'h0, s_q.cyc_mt};
        if (wr) begin
          w = merge(w, wb_dat_i, wb_sel_i);
          s_d.cyc_mt = w[9:0];
          s_d.cyc_lt = w[CYCLE_LT_POS +: 10];
        end
      end
      REG_SPDMIN: begin
        w = {18'h0, s_q.spd_min};
        if (wr) begin
          w = merge(w, wb_dat_i, wb_sel_i);
          s_d.spd_min = w[13:0];
        end
      end
      REG_STATUS: begin
        w = {17'h0, fault, s_q.st != CH_IDLE, s_q.dsel, s_q.shed, s_q.cap,
             s_q.on};
      end
      REG_SHED: begin
        w = {29'h0, s_q.shed};
        if (wr && wb_sel_i[0]) begin
          s_d.shed = s_q.shed & ~wb_dat_i[NCOMP-1:0];
        end
      end
      REG_RUNTIME0: w = s_q.rt[0];
      REG_RUNTIME1: w = s_q.rt[1];
      REG_RUNTIME2: w = s_q.rt[2];
      default: w = '0;
    endcase
    if (s_d.ack && !wb_we_i) begin
      s_d.dat = w;
    end
    // load shedding
    n_en = '0;
    for (int i = 0; i < NCOMP; i++) begin
      n_en = n_en + {2'h0, ~s_q.shed[i] & ~fault[i]};
    end
    floor_en = (s_q.min_en == 2'h0) ? 3'h1 : {1'b0, s_q.min_en};
    excl = '0;
    if (s_q.spd_mode) begin
      excl[di] = 1'b1;
    end
    out_m = s_q.on & ~s_q.shed & ~excl;
    if (shed_msg_i && |out_m && n_en > floor_en) begin
      oi = pick_idx(out_m, s_q.rt, 1'b1);
      s_d.shed[oi] = 1'b1;
    end
    // ordinary run-time rotation
    cond = (|s_q.shed) ? press_rising_i
                       : (press_rising_i && neutral_zone_i);
    out_m = s_q.on & ~excl;
    in_m = ~s_q.on & ~s_q.shed & ~fault & ~excl;
    oi = pick_idx(out_m, s_q.rt, 1'b1);
    ii = pick_idx(in_m, s_q.rt, 1'b0);
    if (s_q.st == CH_IDLE && !s_q.pend && expd && cond) begin
      if (|out_m && |in_m) begin
        s_d.on[oi] = 1'b0;
        s_d.on[ii] = 1'b1;
        s_d.cap[ii] = s_q.cap[oi];
        s_d.cap[oi] = 1'b0;
      end
      s_d.pend = s_q.drv_en[a] && !(|fault[1:0]);
      restart = 1'b1;
    end else if (s_q.st == CH_IDLE && !s_q.pend) begin
      if (stage_up_i && |in_m) begin
        s_d.on[ii] = 1'b1;
      end else if (stage_down_i && |out_m) begin
        s_d.on[oi] = 1'b0;
      end
      if (cap_up_i) begin
        s_d.cap = s_q.cap | (s_q.on & ~s_q.cap & -(s_q.on & ~s_q.cap));
      end else if (cap_down_i) begin
        s_d.cap = s_q.cap & (s_q.cap - 1'b1);
      end
    end
    // drive changeover
    s_d.all_off_prev = ~|s_q.on;
    start = 1'b0;
    if (s_q.st == CH_IDLE) begin
      if (s_q.pend) begin
        s_d.pend = 1'b0;
        if (|s_q.on[1:0]) begin
          start = 1'b1;
        end else begin
          s_d.dsel[a] = ~drv;
        end
      end else if (~|s_q.on && !s_q.all_off_prev && cyc != CYCLE_NONE
                   && s_q.drv_en[a] && !(|fault[1:0])) begin
        s_d.dsel[a] = ~drv;
      end else if (frise[di] && cyc != CYCLE_NONE && s_q.drv_en[a]) begin
        start = 1'b1;
      end
    end
    nxt_spd = {1'b0, s_q.spd} + {1'b0, RAMP_STEP_MV};
    unique case (s_q.st)
      CH_IDLE: begin
        s_d.spd = speed_req_mv_i;
        if (start) begin
          s_d.hold = speed_req_mv_i;
          s_d.both = s_q.on[mi];
          s_d.st = !s_q.on[mi] ? CH_ZERO
                 : (s_q.on[di] ? CH_MIN : CH_MAINS_OFF);
        end
      end
      CH_MIN: begin
        s_d.spd = s_q.spd_min;
        if (ramp_tick) s_d.st = CH_MAINS_OFF;
      end
      CH_MAINS_OFF: begin
        s_d.on[mi] = 1'b0;
        if (ramp_tick) s_d.st = CH_ZERO;
      end
      CH_ZERO: begin
        s_d.spd = '0;
        s_d.on[di] = 1'b0;
        s_d.wait_s = '0;
        if (ramp_tick) s_d.st = CH_WAIT1;
      end
      CH_WAIT1: begin
        if (sec_tick) begin
          s_d.wait_s = s_q.wait_s + 1'b1;
          if (s_q.wait_s == WAIT_LAST) begin
            s_d.dsel[a] = ~drv;
            s_d.wait_s = '0;
            s_d.st = CH_WAIT2;
          end
        end
      end
      CH_WAIT2: begin
        if (sec_tick) begin
          s_d.wait_s = s_q.wait_s + 1'b1;
          if (s_q.wait_s == WAIT_LAST) begin
            s_d.st = s_q.both ? CH_MAINS_ON : CH_DRV_ON;
          end
        end
      end
      CH_MAINS_ON: begin
        s_d.on[mi] = 1'b1;
        if (ramp_tick) s_d.st = CH_DRV_ON;
      end
      CH_DRV_ON: begin
        s_d.on[di] = 1'b1;
        if (ramp_tick) s_d.st = CH_RAMP;
      end
      CH_RAMP: begin
        if (nxt_spd >= {1'b0, s_q.hold}) begin
          s_d.spd = s_q.hold;
          s_d.st = CH_IDLE;
          restart = 1'b1;
        end else if (ramp_tick) begin
          s_d.spd = nxt_spd[13:0];
        end
      end
      default: s_d.st = CH_IDLE;
    endcase
    if (s_q.st != CH_IDLE && |frise[1:0]) begin
      s_d.st = CH_IDLE;
      restart = 1'b1;
    end
    s_d.on = s_d.on & ~fault & ~s_d.shed;
    s_d.cap = s_d.cap & s_d.on;
    s_d.postinj = ~|s_q.drv_en;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.drv_en <= DRV_EN_RST;
      s_q.min_en <= MIN_EN_RST;
      s_q.cyc_mt <= CYCLE_MIN_RST;
      s_q.cyc_lt <= CYCLE_MIN_RST;
      s_q.spd_min <= SPD_MIN_RST;
      s_q.st <= CH_IDLE;
      s_q.all_off_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  cbr_cycle_timer #(
    .W (10)
  ) u_tmr_mt (
    .clk      (clk),
    .nrst     (nrst),
    .min_tick (s_q.min_tick),
    .restart  (restart && !s_q.circ_lt),
    .limit    (s_q.cyc_mt),
    .expired  (exp_mt)
  );

  cbr_cycle_timer #(
    .W (10)
  ) u_tmr_lt (
    .clk      (clk),
    .nrst     (nrst),
    .min_tick (s_q.min_tick),
    .restart  (restart && s_q.circ_lt),
    .limit    (s_q.cyc_lt),
    .expired  (exp_lt)
  );

  assign wb_dat_o        = s_q.dat;
  assign wb_ack_o        = s_q.ack;
  assign comp_on_o       = s_q.on;
  assign cap_on_o        = s_q.cap;
  assign relay7_o        = s_q.dsel[1];
  assign relay8_o        = s_q.dsel[0];
  assign speed_cmd_mv_o  = s_q.spd;
  assign postinj_avail_o = s_q.postinj;
  assign desuper_avail_o = s_q.postinj;
endmodule : cbr_rotation

// file: cbr_rotation_sva.sv
// Purpose: port checks of the rotation block
// Assumes: one clock, asynchronous active-low reset
// Notes:   drive swaps need both drive compressors stopped
`timescale 1ns/1ps
module cbr_rotation_sva
  import cbr_pkg::*;
#(
  parameter int unsigned NCOMP = 3
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             stage_up_i,
  input wire logic             stage_down_i,
  input wire logic             shed_msg_i,
  input wire logic [NCOMP-1:0] comp_fault_i,
  input wire logic [NCOMP-1:0] comp_on_o,
  input wire logic             relay7_o,
  input wire logic             relay8_o,
  input wire logic [13:0]      speed_cmd_mv_o,
  input wire logic             postinj_avail_o,
  input wire logic             desuper_avail_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ack_follows: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_avail_pair: assert property (
    postinj_avail_o == desuper_avail_o)
    else $error("availability outputs differ");
  a_shed_single: assert property (
    shed_msg_i && !stage_up_i && !stage_down_i
    |=> $countones(comp_on_o) + 1 >= $countones($past(comp_on_o)))
    else $error("shed unloaded more than one");
  a_fault_off: assert property (
    comp_fault_i[NCOMP-1] [*6] |-> !comp_on_o[NCOMP-1])
    else $error("faulted compressor still on");
  a_swap_lt_idle: assert property (
    $changed(relay7_o) |-> comp_on_o[1:0] == 2'h0)
    else $error("lt relay moved under load");
  a_swap_mt_idle: assert property (
    $changed(relay8_o) |-> comp_on_o[1:0] == 2'h0)
    else $error("mt relay moved under load");
  a_swap_delay_hold: assert property (
    $changed(relay8_o) |=> (comp_on_o[1:0] == 2'h0) [*8])
    else $error("restart too soon after swap");
endmodule : cbr_rotation_sva

bind cbr_rotation cbr_rotation_sva #(.NCOMP(NCOMP)) u_sva (
  .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .stage_up_i, .stage_down_i, .shed_msg_i, .comp_fault_i,
  .comp_on_o, .relay7_o, .relay8_o, .speed_cmd_mv_o, .postinj_avail_o,
  .desuper_avail_o);

// file: cbr_far_side.sv
// Purpose: far side: shed telegram source, fault pins, speed request
// Assumes: the bench requests a shed with a one-cycle pulse
// Notes:   DLY sets how slowly the telegram follows the request
`timescale 1ns/1ps
module cbr_far_side #(
  parameter int unsigned DLY = 1
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        shed_req,
  input  wire logic [2:0]  fault_req,
  output logic             shed_msg,
  output logic      [2:0]  comp_fault,
  output logic      [13:0] speed_req
);
  logic [7:0] dly_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dly_q <= 8'h00;
      shed_msg <= 1'b0;
      comp_fault <= 3'h0;
    end else begin
      dly_q <= {dly_q[6:0], shed_req};
      shed_msg <= dly_q[DLY-1];
      comp_fault <= fault_req;
    end
  end

  assign speed_req = 14'h1388;
endmodule : cbr_far_side

// file: tb_top.sv
// Purpose: self-checking bench of the rotation block
// Assumes: SEC_CYCLES of 40, so one minute is 2400 cycles
// Notes:   only mismatches and the verdict are printed
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top
  import cbr_pkg::*;
();
  logic        clk;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic        ack;
  logic [4:0]  pl;
  logic        pr;
  logic        nz;
  logic [2:0]  fr;
  logic        shed;
  logic [2:0]  flt;
  logic [13:0] spd;
  logic [13:0] scmd;
  logic [2:0]  on;
  logic [2:0]  cap;
  logic        r7;
  logic        r8;
  logic        rl;
  logic        pa;
  logic        da;
  logic [2:0]  a;
  logic [2:0]  b;
  logic [2:0]  c;
  logic [2:0]  k;
  int          num_errors;
  int          compares;

  cbr_rotation #(.NCOMP(3), .SEC_CYCLES(40)) dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .stage_up_i(pl[0]), .stage_down_i(pl[1]),
    .cap_up_i(pl[2]), .cap_down_i(pl[4]), .press_rising_i(pr),
    .neutral_zone_i(nz), .shed_msg_i(shed), .speed_req_mv_i(spd),
    .comp_fault_i(flt), .drive_relay_nv_i(2'h1), .comp_on_o(on),
    .cap_on_o(cap), .relay7_o(r7), .relay8_o(r8), .speed_cmd_mv_o(scmd),
    .postinj_avail_o(pa), .desuper_avail_o(da));

  cbr_far_side #(.DLY(2)) u_far (
    .clk(clk), .nrst(nrst), .shed_req(pl[3]), .fault_req(fr),
    .shed_msg(shed), .comp_fault(flt), .speed_req(spd));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic fail_out;
    num_errors++;
    wrap_up();
  endtask : fail_out

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) fail_out();
  endtask : wb

  // one-cycle pulse: 0 stage up, 1 stage down, 2 cap up, 3 shed, 4 cap down
  task automatic pulse(input int s);
    @(posedge clk);
    pl <= 5'(1 << s);
    @(posedge clk);
    pl <= 5'h0;
  endtask : pulse

  task automatic wait_chg(input int lim);
    logic [4:0] s0;
    int n;
    s0 = {on, r8, r7};
    n = 0;
    while ({on, r8, r7} === s0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) fail_out();
  endtask : wait_chg

  task automatic t_regs;
    `CHK("relay8 nv", 1'b1, r8)
    `CHK("relay7 nv", 1'b0, r7)
    `CHK("idle speed", 14'h1388, scmd)
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h16, rd)
    wb(1'b0, REG_CYCLE, 32'h0);
    `CHK("cycle", {6'h0, CYCLE_MIN_RST, 6'h0, CYCLE_MIN_RST}, rd)
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("postinj on", 1'b0, pa)
    wb(1'b1, REG_CTRL, 32'h10);
    wb(1'b1, REG_CYCLE, 32'h00010001);
    idle(2);
    `CHK("postinj off", 1'b1, pa)
    `CHK("desuper off", 1'b1, da)
  endtask : t_regs

  task automatic t_rotate;
    pulse(0);
    idle(2);
    a = on;
    idle(200);
    pulse(0);
    idle(2);
    b = on & ~a;
    c = ~(a | b);
    pulse(2);
    idle(2);
    k = (a | b) & (~(a | b) + 3'h1);
    `CHK("cap up", k, cap)
    pulse(4);
    idle(2);
    `CHK("cap down", 3'h0, cap)
    pulse(2);
    idle(4900);
    `CHK("held expiry", a | b, on)
    @(posedge clk);
    nz <= 1'b0;
    pr <= 1'b1;
    idle(8);
    `CHK("zone held", a | b, on)
    nz <= 1'b1;
    @(posedge clk);
    pr <= 1'b1;
    wait_chg(40);
    idle(4);
    `CHK("rotated", b | c, on)
    `CHK("cap copied", (k === a) ? c : k, cap)
    idle(1200);
    `CHK("timer restart", b | c, on)
    @(posedge clk);
    pr <= 1'b0;
  endtask : t_rotate

  task automatic t_shed;
    pulse(3);
    idle(6);
    `CHK("shed longest", c, on)
    wb(1'b0, REG_SHED, 32'h0);
    `CHK("shed mask", {29'h0, b}, rd)
    wb(1'b1, REG_CTRL, 32'h20);
    pulse(3);
    idle(6);
    `CHK("shed floor", c, on)
    wb(1'b1, REG_SHED, 32'h7);
    wb(1'b0, REG_SHED, 32'h0);
    `CHK("shed clear", 32'h0, rd)
  endtask : t_shed

  task automatic t_swap;
    wb(1'b1, REG_CTRL, 32'h16);
    rl = r8;
    pulse(1);
    idle(4);
    `CHK("all stopped", 3'h0, on)
    `CHK("drive swap", ~rl, r8)
    rl = r8;
    idle(300);
  endtask : t_swap

  task automatic t_fault_none;
    int n;
    pulse(0);
    pulse(0);
    @(posedge clk);
    fr <= 3'h1;
    idle(8);
    `CHK("driven off", 3'h4, on)
    `CHK("zero speed", 14'h0, scmd)
    wait_chg(200);
    `CHK("fault swap", ~rl, r8)
    `CHK("swap speed", 14'h0, scmd)
    wait_chg(200);
    n = 0;
    while (scmd !== 14'h1388 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) fail_out();
    `CHK("ramp time", 1'b1, n >= 96 && n <= 104)
    `CHK("driven on", 3'h6, on)
    rl = r8;
    @(posedge clk);
    fr <= 3'h4;
    idle(200);
    `CHK("fixed fault", rl, r8)
    `CHK("fixed off", 1'b0, on[2])
    wb(1'b1, REG_CYCLE, {22'h0, CYCLE_NONE});
    @(posedge clk);
    fr <= 3'h0;
    pulse(1);
    pulse(1);
    pulse(1);
    idle(600);
    `CHK("none idle", 3'h0, on)
    `CHK("none relay", rl, r8)
  endtask : t_fault_none

  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    pl = 5'h0;
    pr = 1'b0;
    nz = 1'b1;
    fr = 3'h0;
    num_errors = 0;
    compares = 0;
    idle(4);
    nrst <= 1'b1;
    idle(5);
    t_regs();
    t_rotate();
    t_shed();
    t_swap();
    t_fault_none();
    wrap_up();
  end
endmodule : tb_top
